// file: rtl/cdc_pkg.sv
// Constants for the capture DMA command control block
package cdc_pkg;
    // Register word addresses
    localparam logic [7:0] CDC_ADDR_CMD = 8'h00;
    localparam logic [7:0] CDC_ADDR_STATUS = 8'h04;
    localparam logic [7:0] CDC_ADDR_CONFIG = 8'h08;
    localparam logic [7:0] CDC_ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] CDC_ADDR_IRQ_CLR = 8'h10;
    localparam logic [7:0] CDC_ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] CDC_ADDR_BANK = 8'h18;
    // Command register fields
    localparam int CDC_CMD_GO_BIT = 0;
    localparam int CDC_CMD_ABORT_BIT = 1;
    localparam int CDC_CMD_RESET_BIT = 2;
    localparam int CDC_CMD_BANK_BIT = 8;
    // Status register fields
    localparam int CDC_ST_READY_BIT = 0;
    localparam int CDC_ST_ABORT_DONE_BIT = 1;
    localparam int CDC_ST_ACTIVE_BIT = 2;
    localparam int CDC_ST_UNDEF_BIT = 3;
    localparam int CDC_ST_BANK_BIT = 4;
    localparam int CDC_ST_FIFO_EMPTY_BIT = 5;
    // Config register fields
    localparam int CDC_CFG_HOST_TABLE_BIT = 0;
    // Interrupt status fields: data events only
    localparam int CDC_IRQ_DRAIN_DONE_BIT = 0;
    localparam int CDC_IRQ_W = 1;
    // Reset values
    localparam logic CDC_RST_BANK = 1'b0;
    localparam logic CDC_RST_HOST_TABLE = 1'b0;
    localparam logic [31:0] CDC_RST_RDATA = 32'h0000_0000;
    // Cycles from abort to stopped (one registered stage)
    localparam int CDC_ABORT_STOP_CYCLES = 1;
endpackage

// file: rtl/cdc_sync2.sv
// Two flip-flop synchroniser for external levels
`timescale 1ns/10ps
module cdc_sync2 #(
    parameter int WIDTH = 1,
    // Reset level per bit; should match the idle level of each pin
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // cdc_sync2

// file: rtl/cdc_dma_cmd_ctrl.sv
// DMA command control: go, abort, reset, bank select and status
`timescale 1ns/10ps
module cdc_dma_cmd_ctrl
    import cdc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Acquisition and data FIFO side (board pins)
    input wire logic acq_active,
    input wire logic fifo_empty,
    // Transfer engine side
    output logic xfer_enable,
    output logic table_bank,
    output logic irq
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic acq_active_s;
    logic fifo_empty_s;

    // FIFO pin idles empty: a low reset level would show a false
    // not-empty status for the two cycles after reset
    cdc_sync2 #(
        .WIDTH(2),
        .RST_VAL(2'h1)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in({acq_active, fifo_empty}),
        .sync_out({acq_active_s, fifo_empty_s})
    );

    // ------------------------------------------------------------
    // Engine state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CDC_IDLE,
        CDC_ARMED,
        CDC_ABORTED
    } cdc_state_t;

    cdc_state_t state_q;
    cdc_state_t state_d;
    logic bank_q;
    logic bank_d;
    logic host_table_q;
    logic host_table_d;
    logic xfer_q;
    logic xfer_d;
    logic abort_done_q;
    logic abort_done_d;
    logic [CDC_IRQ_W-1:0] irq_stat_q;
    logic [CDC_IRQ_W-1:0] irq_stat_d;
    logic [CDC_IRQ_W-1:0] irq_en_q;
    logic [CDC_IRQ_W-1:0] irq_en_d;
    logic irq_q;
    logic irq_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic draining_q;
    logic draining_d;

    logic cmd_wr;
    logic go_cmd;
    logic abort_cmd;
    logic reset_cmd;
    logic drain_done;

    assign cmd_wr = reg_wr && (reg_addr == CDC_ADDR_CMD);
    assign go_cmd = cmd_wr && reg_wdata[CDC_CMD_GO_BIT];
    assign abort_cmd = cmd_wr && reg_wdata[CDC_CMD_ABORT_BIT];
    assign reset_cmd = cmd_wr && reg_wdata[CDC_CMD_RESET_BIT];
    // Transfers that ran past the end of acquisition finish on empty FIFO
    assign drain_done = draining_q && fifo_empty_s;

    always_comb
    begin
        state_d = state_q;
        bank_d = bank_q;
        abort_done_d = abort_done_q;
        draining_d = draining_q;
        // Reset has priority: it is the only way out of the aborted state
        if (reset_cmd)
        begin
            state_d = CDC_IDLE;
            abort_done_d = 1'b0;
            draining_d = 1'b0;
        end
        else if (abort_cmd)
        begin
            // Abort leaves the engine marked undefined; only reset clears it
            // immediate halt
            state_d = CDC_ABORTED;
            abort_done_d = 1'b1;
            draining_d = 1'b0;
        end
        else if (go_cmd && state_q != CDC_ABORTED)
        begin
            state_d = CDC_ARMED;
        end
        if (cmd_wr && !host_table_q)
        begin
            bank_d = reg_wdata[CDC_CMD_BANK_BIT];
        end
        // A cut acquisition still owns the words already in the FIFO
        // track drain after acquisition stops
        if (state_q == CDC_ARMED && xfer_q && !acq_active_s && !reset_cmd && !abort_cmd)
        begin
            draining_d = !fifo_empty_s;
        end
        else if (acq_active_s)
        begin
            draining_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Transfer enable
    // ------------------------------------------------------------
    // Uses the next state so an abort drops the enable at the same edge
    always_comb
    begin
        xfer_d = 1'b0;
        // move only with buffered data, and start only with acquisition
        if (state_d == CDC_ARMED && !fifo_empty_s)
        begin
            // keep going until FIFO is empty
            xfer_d = acq_active_s || xfer_q;
        end
    end

    // ------------------------------------------------------------
    // Registers and interrupt
    // ------------------------------------------------------------
    always_comb
    begin
        host_table_d = host_table_q;
        irq_en_d = irq_en_q;
        if (reg_wr && reg_addr == CDC_ADDR_CONFIG)
        begin
            host_table_d = reg_wdata[CDC_CFG_HOST_TABLE_BIT];
        end
        if (reg_wr && reg_addr == CDC_ADDR_IRQ_EN)
        begin
            irq_en_d = reg_wdata[CDC_IRQ_W-1:0];
        end
        irq_stat_d = irq_stat_q;
        if (reg_wr && reg_addr == CDC_ADDR_IRQ_CLR)
        begin
            irq_stat_d = irq_stat_q & ~reg_wdata[CDC_IRQ_W-1:0];
        end
        // only the drain event interrupts, set beats clear
        if (drain_done)
        begin
            irq_stat_d[CDC_IRQ_DRAIN_DONE_BIT] = 1'b1;
        end
        irq_d = |(irq_stat_d & irq_en_d);
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Read data stand one cycle only, so an idle bus reads zero
    always_comb
    begin
        rdata_d = CDC_RST_RDATA;
        if (reg_rd)
        begin
            case (reg_addr)
                CDC_ADDR_STATUS:
                begin
                    rdata_d[CDC_ST_READY_BIT] = (state_q == CDC_ARMED);
                    rdata_d[CDC_ST_ABORT_DONE_BIT] = abort_done_q && !xfer_q;
                    rdata_d[CDC_ST_ACTIVE_BIT] = xfer_q;
                    rdata_d[CDC_ST_UNDEF_BIT] = (state_q == CDC_ABORTED);
                    rdata_d[CDC_ST_BANK_BIT] = bank_q;
                    rdata_d[CDC_ST_FIFO_EMPTY_BIT] = fifo_empty_s;
                end
                CDC_ADDR_CONFIG:
                begin
                    rdata_d[CDC_CFG_HOST_TABLE_BIT] = host_table_q;
                end
                CDC_ADDR_IRQ_STAT:
                begin
                    rdata_d[CDC_IRQ_W-1:0] = irq_stat_q;
                end
                CDC_ADDR_IRQ_EN:
                begin
                    rdata_d[CDC_IRQ_W-1:0] = irq_en_q;
                end
                CDC_ADDR_BANK:
                begin
                    rdata_d[0] = bank_q;
                end
                default:
                begin
                    // Unmapped and write-only addresses read zero
                    rdata_d = CDC_RST_RDATA;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Engine registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= CDC_IDLE;
            bank_q <= CDC_RST_BANK;
            xfer_q <= 1'b0;
            abort_done_q <= 1'b0;
            draining_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            bank_q <= bank_d;
            xfer_q <= xfer_d;
            abort_done_q <= abort_done_d;
            draining_q <= draining_d;
        end
    end

    // ------------------------------------------------------------
    // Configuration and interrupt registers
    // ------------------------------------------------------------
    // The interrupt is registered so the output comes from a flip-flop; it is built
    // from the next status and enable, so it adds no cycle after the status bit
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            host_table_q <= CDC_RST_HOST_TABLE;
            irq_stat_q <= '0;
            irq_en_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            host_table_q <= host_table_d;
            irq_stat_q <= irq_stat_d;
            irq_en_q <= irq_en_d;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_q <= CDC_RST_RDATA;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    assign reg_rdata = rdata_q;
    assign xfer_enable = xfer_q;
    assign table_bank = bank_q;
    assign irq = irq_q;
endmodule // cdc_dma_cmd_ctrl

// file: bench/cdc_dma_cmd_monitor.sv
// Port assertions for the DMA command control block
`timescale 1ns/10ps
module cdc_dma_cmd_monitor
    import cdc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic acq_active,
    input wire logic fifo_empty,
    input wire logic xfer_enable,
    input wire logic table_bank,
    input wire logic irq
);
    wire cmd_w = reg_wr && reg_addr == CDC_ADDR_CMD;
    wire st_r = reg_rd && reg_addr == CDC_ADDR_STATUS;
    wire en_w = reg_wr && reg_addr == CDC_ADDR_IRQ_EN;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    AST_ABORT_STOPS: assert property (cmd_w && reg_wdata[2:1] == 2'h1 |=> !xfer_enable)
        else $error("moving after abort");
    // Pin levels need three edges to reach the output
    AST_EMPTY_IDLE: assert property (fifo_empty [*4] |-> !xfer_enable)
        else $error("moving with empty fifo");
    AST_NO_ACQ: assert property ((!acq_active) [*4] ##0 !xfer_enable |=> !xfer_enable)
        else $error("started without acquisition");
    AST_DRAIN: assert property ((!fifo_empty && !reg_wr) [*4] ##0 xfer_enable
        |=> xfer_enable)
        else $error("stopped before fifo empty");
    AST_GO_LOCKED: assert property (cmd_w && reg_wdata[2:0] == 3'h2 ##1
        (!(cmd_w && reg_wdata[2])) [*5] |-> !xfer_enable)
        else $error("go accepted while aborted");
    AST_GO_READY: assert property (cmd_w && reg_wdata[2:0] == 3'h4 ##1
        cmd_w && reg_wdata[2:0] == 3'h1 ##1 st_r |=> reg_rdata[0])
        else $error("not ready after go");
    AST_ABORT_SEEN: assert property (cmd_w && reg_wdata[2:0] == 3'h2 ##1 st_r
        |=> reg_rdata[1] && reg_rdata[3])
        else $error("abort completion not shown");
    AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(fifo_empty) || $past(en_w)
        || $past(en_w, 2))
        else $error("interrupt without data event");
    // Status and other read data stand only in the cycle after the strobe
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
endmodule // cdc_dma_cmd_monitor

bind cdc_dma_cmd_ctrl cdc_dma_cmd_monitor cdc_dma_cmd_monitor_i (.sys_clk(sys_clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acq_active(acq_active),
    .fifo_empty(fifo_empty), .xfer_enable(xfer_enable), .table_bank(table_bank), .irq(irq));

// file: bench/cdc_fifo_model.sv
// Behavioural model of acquisition and the board data FIFO
`timescale 1ns/10ps
module cdc_fifo_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic acq_req,
    input wire logic [7:0] fill,
    input wire logic xfer_enable,
    output logic acq_active,
    output logic fifo_empty
);
    logic [8:0] count_q;
    assign fifo_empty = (count_q == 9'h000);
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_q <= 9'h000;
            acq_active <= 1'b0;
        end
        else
        begin
            acq_active <= acq_req;
            if (fill != 8'h00)
                count_q <= count_q + {1'h0, fill};
            else if (xfer_enable && !fifo_empty)
                count_q <= count_q - 9'h001;
        end
    end
endmodule // cdc_fifo_model

// file: bench/tb.sv
// Self-checking testbench for the DMA command control block
`timescale 1ns/10ps
module tb;
    import cdc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic acq_req = 1'b0;
    logic [7:0] fill = 8'h00;
    logic [31:0] reg_rdata;
    logic acq_active, fifo_empty, xfer_enable, table_bank, irq;
    int n_fail = 0;
    int cmp_count = 0;
    initial forever #2 sys_clk = ~sys_clk;
    cdc_dma_cmd_ctrl cdc_dma_cmd_ctrl_i (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .acq_active(acq_active), .fifo_empty(fifo_empty), .xfer_enable(xfer_enable),
        .table_bank(table_bank), .irq(irq));
    cdc_fifo_model cdc_fifo_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .acq_req(acq_req),
        .fill(fill), .xfer_enable(xfer_enable), .acq_active(acq_active),
        .fifo_empty(fifo_empty));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Write strobe is left high so back-to-back writes never toggle it twice
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, string n);
        reg_wr <= 1'b0;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(n, e, reg_rdata & m);
        @(posedge sys_clk);
    endtask
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_x(input logic v);
        reg_wr <= 1'b0;
        for (int i = 0; i < 80 && xfer_enable !== v; i++) @(posedge sys_clk);
        chk("xfer_enable", v, xfer_enable);
        if (xfer_enable !== v)
            stop_test();
    endtask
    task automatic load(input logic [7:0] w);
        fill <= w;
        @(posedge sys_clk);
        fill <= 8'h00;
    endtask
    task automatic poll_st(input logic [31:0] m, input logic [31:0] e, input string n);
        logic [31:0] got;
        got = ~e;
        for (int i = 0; i < 16 && got !== e; i++)
        begin
            reg_wr <= 1'b0;
            reg_addr <= CDC_ADDR_STATUS;
            reg_rd <= 1'b1;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1;
            got = reg_rdata & m;
            @(posedge sys_clk);
        end
        chk(n, e, got);
        if (got !== e)
            stop_test();
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_go();
        wr(CDC_ADDR_CMD, 32'h4);
        wr(CDC_ADDR_CMD, 32'h1);
        rd(CDC_ADDR_STATUS, 32'h9, 32'h1, "ready");
        // engine stays armed, acquisition gates data
        load(8'h14);
        idle(8);
        chk("xfer_enable", 1'b0, xfer_enable);
        acq_req <= 1'b1;
        wait_x(1'b1);
        acq_req <= 1'b0;
        wait_x(1'b0);
        chk("fifo_empty", 1'b1, fifo_empty);
    endtask
    task automatic t_irq();
        rd(CDC_ADDR_IRQ_STAT, 32'h1, 32'h1, "drain_done");
        wr(CDC_ADDR_IRQ_EN, 32'h1);
        rd(CDC_ADDR_IRQ_EN, 32'hFFFFFFFF, 32'h1, "irq_enable");
        idle(3);
        chk("irq", 1'b1, irq);
        wr(CDC_ADDR_IRQ_EN, 32'h0);
        idle(3);
        chk("irq", 1'b0, irq);
        wr(CDC_ADDR_IRQ_CLR, 32'h1);
        rd(CDC_ADDR_IRQ_STAT, 32'h1, 32'h0, "irq_cleared");
        wr(CDC_ADDR_IRQ_EN, 32'h1);
        idle(3);
        chk("irq", 1'b0, irq);
    endtask
    task automatic t_abort();
        acq_req <= 1'b1;
        load(8'h40);
        wait_x(1'b1);
        wr(CDC_ADDR_CMD, 32'h2);
        rd(CDC_ADDR_STATUS, 32'hE, 32'hA, "abort_done");
        poll_st(32'h2, 32'h2, "abort_poll");
        chk("xfer_enable", 1'b0, xfer_enable);
        chk("fifo_empty", 1'b0, fifo_empty);
        wr(CDC_ADDR_CMD, 32'h1);
        idle(6);
        chk("xfer_enable", 1'b0, xfer_enable);
        chk("irq", 1'b0, irq);
        wr(CDC_ADDR_CMD, 32'h4);
        wr(CDC_ADDR_CMD, 32'h1);
        wait_x(1'b1);
        acq_req <= 1'b0;
        wait_x(1'b0);
    endtask
    task automatic t_bank();
        wr(CDC_ADDR_CMD, 32'h100);
        idle(1);
        chk("table_bank", 1'b1, table_bank);
        rd(CDC_ADDR_BANK, 32'h1, 32'h1, "bank");
        wr(CDC_ADDR_CONFIG, 32'h1);
        rd(CDC_ADDR_CONFIG, 32'hFFFFFFFF, 32'h1, "host_table");
        wr(CDC_ADDR_CMD, 32'h0);
        idle(1);
        chk("table_bank", 1'b1, table_bank);
        wr(CDC_ADDR_CONFIG, 32'h0);
        wr(CDC_ADDR_CMD, 32'h0);
        idle(1);
        chk("table_bank", 1'b0, table_bank);
    endtask
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rd(CDC_ADDR_STATUS, 32'hFFFFFFFF, 32'h20, "status");
        rd(8'hFC, 32'hFFFFFFFF, 32'h0, "unmapped");
        t_go();
        t_irq();
        t_abort();
        t_bank();
        stop_test();
    end
endmodule // tb
